// ===== core/adcs_map.svh
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH
// register offsets on the 3-bit address port
`define ADCS_OFF_SC1 3'h0
`define ADCS_OFF_SC2 3'h1
`define ADCS_OFF_CFG 3'h2
`define ADCS_OFF_CVH 3'h3
`define ADCS_OFF_CVL 3'h4
`define ADCS_OFF_RH 3'h5
`define ADCS_OFF_RL 3'h6
// field positions
`define ADCS_SC1_DONE 7
`define ADCS_SC1_IEN 6
`define ADCS_SC1_CONT 5
`define ADCS_SC2_ACT 7
`define ADCS_SC2_TRG 6
`define ADCS_SC2_CMPEN 5
`define ADCS_SC2_CMPGT 4
`define ADCS_CFG_LPC 7
`define ADCS_CFG_LSMP 4
// field encodings
`define ADCS_CH_OFF 5'h1f
`define ADCS_MODE_8 2'h0
`define ADCS_MODE_10 2'h2
`define ADCS_CLK_BUS 2'h0
`define ADCS_CLK_BUS2 2'h1
`define ADCS_CLK_ALT 2'h2
`define ADCS_CLK_ASYNC 2'h3
// reset values
`define ADCS_CH_RST 5'h1f
`define ADCS_CFG_RST 8'h00
`define ADCS_CV_RST 12'h000
`define ADCS_RES_RST 12'h000
// timing
`define ADCS_CLK_PERIOD_NS 50
`define ADCS_ASYNC_START_NS 5000
`define ADCS_ASYNC_START_CYC 7'(`ADCS_ASYNC_START_NS / `ADCS_CLK_PERIOD_NS)
`define ADCS_SMP_SHORT 5'd4
`define ADCS_SMP_LONG 5'd24
`define ADCS_XFER_CYC 7'd2
`define ADCS_BITS_8 4'd9
`define ADCS_BITS_HI 4'd12
`endif

// ===== core/adcs_pkg.sv
package adcs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_SAMPLE,
		ST_CONV,
		ST_XFER
	} adcs_state_e;

	typedef struct packed {
		adcs_state_e st;
		logic        done;
		logic        ien;
		logic        cont;
		logic [4:0]  ch;
		logic        trg;
		logic        cmpen;
		logic        cmpgt;
		logic [7:0]  cfg;
		logic [11:0] cv;
		logic [11:0] res;
		logic [7:0]  rdata;
		logic        hip;
		logic        first;
		logic        trig_prev;
		logic        half;
		logic [2:0]  div;
		logic [6:0]  cnt;
		logic [11:0] trial;
		logic [11:0] mask;
	} adcs_regs_s;
endpackage

// ===== core/adcs_sequencer.sv
`timescale 1ns/1ps
`include "adcs_map.svh"

module adcs_sequencer #(
	parameter int RES_W = 12
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic [2:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic        STOP_MODE,
	input  wire logic        STOP2_MODE,
	input  wire logic        HW_TRIGGER,
	input  wire logic        ALT_TICK,
	input  wire logic        ASYNC_TICK,
	input  wire logic        COMP_IN,
	output logic             CONV_IRQ,
	output logic             ASYNC_CLK_EN,
	output logic             SAMPLE_EN,
	output logic             ACTIVE,
	output logic             LOW_POWER,
	output logic      [4:0]  CHANNEL,
	output logic      [11:0] DAC_CODE
);
	generate
		if (RES_W != 12) begin : g_chk
			$error("adcs_sequencer serves a 12-bit converter only");
		end
	endgenerate

	localparam adcs_pkg::adcs_regs_s RST = '{
		st:    adcs_pkg::ST_IDLE,
		ch:    `ADCS_CH_RST,
		cfg:   `ADCS_CFG_RST,
		cv:    `ADCS_CV_RST,
		res:   `ADCS_RES_RST,
		default: '0
	};

	adcs_pkg::adcs_regs_s q;
	adcs_pkg::adcs_regs_s d;

	logic [1:0]  csel;
	logic [1:0]  divsel;
	logic [1:0]  mode;
	logic        m8;
	logic        lsmp;
	logic        src_tick;
	logic [2:0]  divlim;
	logic        ctick;
	logic        trig_edge;
	logic [4:0]  need;
	logic [3:0]  nbits;
	logic [12:0] up8;
	logic [12:0] up10;
	logic [11:0] rnd;
	logic [11:0] cvv;
	logic [12:0] sum;
	logic        cmp_ok;
	logic [11:0] store;
	logic        blocked;
	logic        stop_abort;

	assign csel = q.cfg[1:0];
	assign divsel = q.cfg[6:5];
	assign mode = q.cfg[3:2];
	assign m8 = (mode == `ADCS_MODE_8);
	assign lsmp = q.cfg[`ADCS_CFG_LSMP];
	assign need = lsmp ? `ADCS_SMP_LONG : `ADCS_SMP_SHORT;
	assign nbits = m8 ? `ADCS_BITS_8 : `ADCS_BITS_HI;

	// all three synchronous sources stay selectable with low power set, but stop mode aborts conversions on them
	always_comb begin
		case (csel)
			`ADCS_CLK_BUS: src_tick = 1'b1;
			`ADCS_CLK_BUS2: src_tick = q.half;
			`ADCS_CLK_ALT: src_tick = ALT_TICK;
			default: src_tick = ASYNC_TICK;
		endcase
	end

	assign divlim = 3'((4'h1 << divsel) - 4'h1);
	assign ctick = src_tick && (q.div == divlim);
	assign trig_edge = HW_TRIGGER && !q.trig_prev;

	// rounding saturates so that full scale does not wrap to zero
	assign up8 = {4'h0, q.trial[8:0]} + 13'h1;
	assign up10 = {1'b0, q.trial} + 13'h2;
	always_comb begin
		if (m8) begin
			rnd = up8[9] ? 12'h0ff : {4'h0, up8[8:1]};
		end else if (mode == `ADCS_MODE_10) begin
			rnd = up10[12] ? 12'h3ff : {2'h0, up10[11:2]};
		end else begin
			rnd = q.trial;
		end
	end

	assign cvv = m8 ? {4'h0, q.cv[7:0]} : q.cv;
	// carry out of the sum means no borrow, i.e. result >= compare
	assign sum = {1'b0, rnd} + {1'b0, ~cvv} + 13'h1;
	assign cmp_ok = q.cmpgt ? sum[12] : !sum[12];
	assign store = q.cmpen ? sum[11:0] : rnd;
	assign blocked = q.hip && !m8;
	// with the async clock the converter keeps running in stop3
	assign stop_abort = STOP_MODE && (csel != `ADCS_CLK_ASYNC);

	function automatic adcs_pkg::adcs_regs_s go(
		input adcs_pkg::adcs_regs_s s,
		input logic                 fresh,
		input logic [1:0]           cs
	);
		// startup delay only ahead of the first conversion of a run
		if (fresh && cs == `ADCS_CLK_ASYNC) begin
			s.st = adcs_pkg::ST_START;
		end else begin
			s.st = adcs_pkg::ST_SAMPLE;
		end
		s.first = fresh;
		s.cnt = '0;
		s.div = '0;
		return s;
	endfunction

	always_comb begin
		d = q;
		d.half = ~q.half;
		d.trig_prev = HW_TRIGGER;
		d.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				`ADCS_OFF_SC1: d.rdata = {q.done, q.ien, q.cont, q.ch};
				`ADCS_OFF_SC2: d.rdata = {q.st != adcs_pkg::ST_IDLE, q.trg, q.cmpen, q.cmpgt, 4'h0};
				`ADCS_OFF_CFG: d.rdata = q.cfg;
				`ADCS_OFF_CVH: d.rdata = {4'h0, q.cv[11:8]};
				`ADCS_OFF_CVL: d.rdata = q.cv[7:0];
				`ADCS_OFF_RH: d.rdata = {4'h0, q.res[11:8]};
				`ADCS_OFF_RL: d.rdata = q.res[7:0];
				default: d.rdata = 8'h00;
			endcase
		end
		// outside 8-bit mode, a pending high-byte read guards the pair until the low byte is read
		if (RD && ADDR == `ADCS_OFF_RH && !m8) begin
			d.hip = 1'b1;
		end
		if (RD && ADDR == `ADCS_OFF_RL) begin
			d.hip = 1'b0;
			d.done = 1'b0;
		end
		if (WR && ADDR == `ADCS_OFF_SC1) begin
			d.done = 1'b0;
		end

		if (q.st == adcs_pkg::ST_IDLE) begin
			d.div = '0;
		end else if (src_tick) begin
			d.div = ctick ? 3'h0 : 3'(q.div + 3'h1);
		end

		case (q.st)
			adcs_pkg::ST_IDLE: begin
				// continuous runs only ever see the launching edge
				if (q.trg && trig_edge && q.ch != `ADCS_CH_OFF) begin
					d = go(d, 1'b1, csel);
				end
			end
			adcs_pkg::ST_START: begin
				d.cnt = 7'(q.cnt + 7'h1);
				if (q.cnt == `ADCS_ASYNC_START_CYC - 7'h1) begin
					d.st = adcs_pkg::ST_SAMPLE;
					d.cnt = '0;
					d.div = '0;
				end
			end
			adcs_pkg::ST_SAMPLE: begin
				// a slow bus clock stretches this phase; timing is exact only
				// while the bus clock keeps up with the converter clock
				if (ctick) begin
					d.cnt = 7'(q.cnt + 7'h1);
					if (q.cnt == {2'h0, need} - 7'h1) begin
						d.st = adcs_pkg::ST_CONV;
						d.cnt = '0;
						d.trial = 12'h001 << (nbits - 4'h1);
						d.mask = 12'h001 << (nbits - 4'h1);
					end
				end
			end
			adcs_pkg::ST_CONV: begin
				if (ctick) begin
					d.trial = COMP_IN ? q.trial : (q.trial & ~q.mask);
					d.mask = q.mask >> 1;
					if (q.mask[0]) begin
						d.st = adcs_pkg::ST_XFER;
						d.cnt = '0;
					end else begin
						d.trial = d.trial | (q.mask >> 1);
					end
				end
			end
			adcs_pkg::ST_XFER: begin
				// short bus-clock tail; total stays under 20/23 or 40/43
				// converter cycles plus 5 bus cycles, and 100 bus cycles more after an async startup
				d.cnt = 7'(q.cnt + 7'h1);
				if (q.cnt == `ADCS_XFER_CYC - 7'h1) begin
					d.st = adcs_pkg::ST_IDLE;
					d.first = 1'b0;
					if (blocked) begin
						// a blocked result is lost; the converter tries again unless a compare fails outside continuous mode
						if (!(q.cmpen && !cmp_ok && !q.cont)) begin
							d = go(d, 1'b0, csel);
						end
					end else if (q.cmpen && !cmp_ok) begin
						if (q.cont) begin
							d = go(d, 1'b0, csel);
						end
					end else begin
						d.res = store;
						d.done = 1'b1;
						// follow-on conversions skip the async startup but still pass through the bus-clock transfer tail
						if (q.cont) begin
							d = go(d, 1'b0, csel);
						end
					end
				end
			end
			default: d.st = adcs_pkg::ST_IDLE;
		endcase

		// outside reset and stop2, result registers are only loaded in the transfer step above
		if (stop_abort) begin
			d.st = adcs_pkg::ST_IDLE;
		end

		if (WR) begin
			case (ADDR)
				`ADCS_OFF_SC1: begin
					d.ien = WDATA[`ADCS_SC1_IEN];
					d.cont = WDATA[`ADCS_SC1_CONT];
					d.ch = WDATA[4:0];
					d.st = adcs_pkg::ST_IDLE;
					if (WDATA[4:0] != `ADCS_CH_OFF && !q.trg) begin
						d = go(d, 1'b1, csel);
					end
				end
				`ADCS_OFF_SC2: begin
					d.trg = WDATA[`ADCS_SC2_TRG];
					d.cmpen = WDATA[`ADCS_SC2_CMPEN];
					d.cmpgt = WDATA[`ADCS_SC2_CMPGT];
					d.st = adcs_pkg::ST_IDLE;
				end
				`ADCS_OFF_CFG: begin
					d.cfg = WDATA;
					d.st = adcs_pkg::ST_IDLE;
				end
				`ADCS_OFF_CVH: begin
					d.cv[11:8] = WDATA[3:0];
					d.st = adcs_pkg::ST_IDLE;
				end
				`ADCS_OFF_CVL: begin
					d.cv[7:0] = WDATA;
					d.st = adcs_pkg::ST_IDLE;
				end
				default: begin
				end
			endcase
		end
	end

	// stop2 wipes everything just as a reset does
	always_ff @(posedge CLK) begin
		if (!RESETN || STOP2_MODE) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	assign RDATA = q.rdata;
	assign CONV_IRQ = q.done && q.ien;
	// generator runs only while a conversion is pending
	assign ASYNC_CLK_EN = (q.st != adcs_pkg::ST_IDLE) && (csel == `ADCS_CLK_ASYNC);
	assign SAMPLE_EN = (q.st == adcs_pkg::ST_SAMPLE);
	assign ACTIVE = (q.st != adcs_pkg::ST_IDLE);
	assign LOW_POWER = q.cfg[`ADCS_CFG_LPC];
	assign CHANNEL = q.ch;
	assign DAC_CODE = q.trial;

	logic [5:0] h_smp;
	always_ff @(posedge CLK) begin
		// a restart from within sampling begins a fresh count
		if (!RESETN || !SAMPLE_EN || (WR && ADDR == `ADCS_OFF_SC1)) begin
			h_smp <= 6'h00;
		end else if (ctick) begin
			h_smp <= 6'(h_smp + 6'h01);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN || STOP2_MODE);

	sc1_restart_a: assert property (
		(WR && ADDR == `ADCS_OFF_SC1 && WDATA[4:0] != `ADCS_CH_OFF && !q.trg)
		|=> (q.st == adcs_pkg::ST_SAMPLE || q.st == adcs_pkg::ST_START)
	) else $error("control one write did not restart");
	mode_abort_a: assert property (
		(WR && ADDR inside {`ADCS_OFF_SC2, `ADCS_OFF_CFG, `ADCS_OFF_CVH, `ADCS_OFF_CVL})
		|=> !ACTIVE
	) else $error("mode write did not abort");
	result_hold_a: assert property (
		(q.st != adcs_pkg::ST_XFER) |=> $stable(q.res)
	) else $error("result changed outside transfer");
	stop_idle_a: assert property (
		(STOP_MODE && csel != `ADCS_CLK_ASYNC && !WR) |=> !ACTIVE ##1 $stable(q.res) || !STOP_MODE
	) else $error("stop did not idle converter");
	async_off_a: assert property (
		(!ACTIVE && !WR && !(q.trg && trig_edge)) |=> !ASYNC_CLK_EN
	) else $error("async generator left running");
	start_clock_a: assert property (
		(q.st == adcs_pkg::ST_START) |-> ASYNC_CLK_EN && q.first
	) else $error("startup without async generator");
	follow_on_a: assert property (
		(q.st == adcs_pkg::ST_XFER && q.cnt == `ADCS_XFER_CYC - 7'h1 && q.cont && !blocked
			&& !(q.cmpen && !cmp_ok) && !WR && !stop_abort) |=> SAMPLE_EN
	) else $error("follow-on conversion not sampling");
	sample_len_a: assert property (
		(q.st == adcs_pkg::ST_CONV && $past(q.st) == adcs_pkg::ST_SAMPLE)
		|-> h_smp == (lsmp ? 6'd24 : 6'd4)
	) else $error("sample phase length wrong");
	irq_raise_a: assert property (
		(q.st == adcs_pkg::ST_XFER && q.cnt == `ADCS_XFER_CYC - 7'h1 && !blocked
			&& !(q.cmpen && !cmp_ok) && q.ien && !WR) |=> CONV_IRQ
	) else $error("interrupt missing on done");
	cmp_false_a: assert property (
		(q.st == adcs_pkg::ST_XFER && d.st != adcs_pkg::ST_XFER && q.cmpen && !cmp_ok)
		|=> $stable(q.res) && !$rose(q.done)
	) else $error("false compare updated results");
	block_drop_a: assert property (
		(q.st == adcs_pkg::ST_XFER && blocked && !(RD && ADDR == `ADCS_OFF_RL))
		|=> $stable(q.res) && !$rose(q.done)
	) else $error("blocked result was transferred");
	trig_ignore_a: assert property (
		(q.st == adcs_pkg::ST_CONV && trig_edge && !WR && !stop_abort)
		|=> q.st != adcs_pkg::ST_SAMPLE
	) else $error("trigger edge restarted busy converter");
endmodule // adcs_sequencer

// ===== testbench/adcs_analog_src.sv
`timescale 1ns/1ps

module adcs_analog_src (
	input  wire logic        CLK,
	input  wire logic        SAMPLE_EN,
	input  wire logic [11:0] VIN,
	input  wire logic [11:0] DAC_CODE,
	output logic             COMP_IN
);
	logic [11:0] held_q;

	// the hold node tracks the input only while the switch is closed, so late input moves stay unseen
	always @(posedge CLK) begin
		if (SAMPLE_EN === 1'b1) begin
			held_q <= VIN;
		end
	end

	assign COMP_IN = (held_q >= DAC_CODE);
endmodule // adcs_analog_src

// ===== testbench/adcs_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "adcs_map.svh"

module adcs_sequencer_tb_top;
	typedef struct {
		logic [7:0]  cfg;
		logic [7:0]  sc2;
		logic [7:0]  sc1;
		logic [11:0] cv;
		logic [11:0] vin;
	} adcs_row_s;

	logic        clk;
	logic        resetn;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic [7:0]  rdata;
	logic        stop_mode;
	logic        stop2_mode;
	logic        hw_trigger;
	logic        alt_tick;
	logic        async_tick;
	logic        comp_in;
	logic        conv_irq;
	logic        async_clk_en;
	logic        sample_en;
	logic        active;
	logic        low_power;
	logic [4:0]  channel;
	logic [11:0] dac_code;
	logic [11:0] vin;
	logic [11:0] last;
	logic [11:0] r;
	logic [11:0] e;
	logic [7:0]  d;
	logic [7:0]  h;
	logic [1:0]  tk;
	logic        fl;
	bit          seen;
	bit          ae;
	int          t;
	int          lim;
	int          p;
	int          n_mismatch;
	int          cmp_count;
	adcs_row_s   w;
	adcs_row_s   rows [11] = '{
		'{8'h04, 8'h00, 8'h41, 12'h000, 12'h9a5},
		'{8'h00, 8'h00, 8'h41, 12'h000, 12'h0b5},
		'{8'h08, 8'h00, 8'h41, 12'h000, 12'h9a6},
		'{8'h14, 8'h00, 8'h01, 12'h000, 12'h123},
		'{8'h25, 8'h00, 8'h41, 12'h000, 12'hfff},
		'{8'h06, 8'h00, 8'h41, 12'h000, 12'h000},
		'{8'h07, 8'h00, 8'h41, 12'h000, 12'h5a5},
		'{8'h04, 8'h30, 8'h41, 12'h400, 12'h9a5},
		'{8'h04, 8'h30, 8'h41, 12'ha00, 12'h9a5},
		'{8'h04, 8'h20, 8'h41, 12'ha00, 12'h9a5},
		'{8'h04, 8'h20, 8'h41, 12'h100, 12'h9a5}};

	adcs_sequencer u_adcs_sequencer (
		.CLK         (clk),
		.RESETN      (resetn),
		.ADDR        (addr),
		.WDATA       (wdata),
		.WR          (wr_stb),
		.RD          (rd_stb),
		.RDATA       (rdata),
		.STOP_MODE   (stop_mode),
		.STOP2_MODE  (stop2_mode),
		.HW_TRIGGER  (hw_trigger),
		.ALT_TICK    (alt_tick),
		.ASYNC_TICK  (async_tick),
		.COMP_IN     (comp_in),
		.CONV_IRQ    (conv_irq),
		.ASYNC_CLK_EN(async_clk_en),
		.SAMPLE_EN   (sample_en),
		.ACTIVE      (active),
		.LOW_POWER   (low_power),
		.CHANNEL     (channel),
		.DAC_CODE    (dac_code)
	);

	adcs_analog_src u_adcs_analog_src (
		.CLK      (clk),
		.SAMPLE_EN(sample_en),
		.VIN      (vin),
		.DAC_CODE (dac_code),
		.COMP_IN  (comp_in)
	);

	initial clk = 1'b0;
	always #25 clk = ~clk;

	// alternate source ticks every 2nd cycle, the async source every 3rd
	always @(posedge clk) begin
		tk <= (tk == 2'd2) ? 2'd0 : tk + 2'd1;
		async_tick <= (tk == 2'd0);
		alt_tick <= ~alt_tick;
	end

	task chk(input logic [11:0] got, input logic [11:0] ex, input string m);
		cmp_count++;
		if (got !== ex) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, ex);
		end
	endtask

	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task rdchk(input logic [2:0] a, input logic [7:0] ex, input string m);
		logic [7:0] v;
		rd(a, v);
		chk({4'h0, v}, {4'h0, ex}, m);
	endtask

	task res(input logic [11:0] ex);
		logic [7:0] hi;
		logic [7:0] lo;
		rd(`ADCS_OFF_RH, hi);
		rd(`ADCS_OFF_RL, lo);
		chk({hi[3:0], lo}, ex, "result");
	endtask

	// counts cycles until a seen conversion ends, or the limit
	task run(input int n);
		t = 0;
		seen = 0;
		ae = 0;
		while (t < n && !(seen && active === 1'b0)) begin
			@(negedge clk);
			t++;
			if (active === 1'b1) seen = 1;
			if (async_clk_en === 1'b1) ae = 1;
		end
	endtask

	task edge_wait;
		t = 0;
		while (sample_en !== 1'b0 && t < 200) begin
			@(negedge clk);
			t++;
		end
		while (sample_en !== 1'b1 && t < 200) begin
			@(negedge clk);
			t++;
		end
	endtask

	task final_report;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		{resetn, addr, wdata, wr_stb, rd_stb, stop_mode, stop2_mode, hw_trigger} = '0;
		{vin, last, tk, alt_tick, async_tick, n_mismatch, cmp_count} = '0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rdchk(`ADCS_OFF_SC1, 8'h1f, "sc1 reset");
		for (int a = 1; a < 8; a++) rdchk(3'(a), 8'h00, "reg reset");
		chk({7'h0, channel}, 12'h01f, "channel");
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			w = rows[i];
			wr(`ADCS_OFF_CFG, w.cfg);
			wr(`ADCS_OFF_SC2, w.sc2);
			wr(`ADCS_OFF_CVH, {4'h0, w.cv[11:8]});
			wr(`ADCS_OFF_CVL, w.cv[7:0]);
			vin <= w.vin;
			p = (w.cfg[1:0] == 2'h0) ? 1 : (w.cfg[1:0] == 2'h3) ? 3 : 2;
			p = p << w.cfg[6:5];
			lim = p * ((w.cfg[4] ? 40 : 20) + ((w.cfg[3:2] == 2'h0) ? 0 : 3)) + 5 + ((w.cfg[1:0] == 2'h3) ? 100 : 0);
			// vin is given in units of the trial word: 9 bits in 8-bit mode
			r = w.vin;
			if (w.cfg[3:2] == 2'h0) r = (w.vin[8:0] == 9'h1ff) ? 12'h0ff : 12'((10'(w.vin[8:0]) + 10'h1) >> 1);
			if (w.cfg[3:2] == 2'h2) r = (w.vin > 12'hffd) ? 12'h3ff : 12'((13'(w.vin) + 13'h2) >> 2);
			fl = !w.sc2[5] || (w.sc2[4] ? r >= w.cv : r < w.cv);
			e = fl ? (w.sc2[5] ? r + ~w.cv + 12'h1 : r) : last;
			wr(`ADCS_OFF_SC1, w.sc1);
			run(lim + 20);
			chk(12'(t <= lim), 12'h1, "conv time");
			chk(12'(conv_irq), 12'(fl & w.sc1[6]), "irq");
			chk(12'(async_clk_en), 12'h0, "async idle");
			if (w.cfg[1:0] == 2'h3) chk(12'(ae), 12'h1, "async on");
			rd(`ADCS_OFF_SC1, d);
			chk(12'(d[7]), 12'(fl), "done flag");
			res(e);
			last = e;
			$display("row %0d done", i);
		end
		for (int a = 1; a < 5; a++) begin
			vin <= 12'h777;
			wr(`ADCS_OFF_SC1, 8'h01);
			repeat (8) @(posedge clk);
			wr(3'(a), (a == 2) ? 8'h04 : 8'h00);
			repeat (2) @(negedge clk);
			chk(12'(active), 12'h0, "abort");
		end
		rd(`ADCS_OFF_SC1, d);
		chk(12'(d[7]), 12'h0, "no done");
		res(last);
		wr(`ADCS_OFF_SC1, 8'h01);
		repeat (8) @(posedge clk);
		vin <= 12'h3c3;
		wr(`ADCS_OFF_SC1, 8'h41);
		run(40);
		chk(12'(t <= 28), 12'h1, "restart time");
		res(12'h3c3);
		wr(`ADCS_OFF_SC1, 8'h5f);
		run(30);
		chk(12'(seen), 12'h0, "off channel");
		$display("test abort done");
		vin <= 12'h0f0;
		wr(`ADCS_OFF_SC1, 8'h01);
		repeat (6) @(posedge clk);
		stop_mode <= 1'b1;
		repeat (2) @(negedge clk);
		chk(12'(active), 12'h0, "stop abort");
		@(posedge clk);
		stop_mode <= 1'b0;
		run(40);
		chk(12'(seen), 12'h0, "stay idle");
		res(12'h3c3);
		wr(`ADCS_OFF_CFG, 8'h07);
		wr(`ADCS_OFF_SC1, 8'h01);
		repeat (20) @(posedge clk);
		stop_mode <= 1'b1;
		run(200);
		chk(12'(t < 200), 12'h1, "stop3 runs");
		@(posedge clk);
		stop_mode <= 1'b0;
		res(12'h0f0);
		$display("test stop done");
		wr(`ADCS_OFF_CFG, 8'h04);
		wr(`ADCS_OFF_SC2, 8'h40);
		vin <= 12'h456;
		wr(`ADCS_OFF_SC1, 8'h41);
		@(posedge clk);
		hw_trigger <= 1'b1;
		repeat (3) @(posedge clk);
		hw_trigger <= 1'b0;
		repeat (3) @(posedge clk);
		hw_trigger <= 1'b1;
		run(40);
		chk(12'(t <= 14), 12'h1, "busy edge");
		@(posedge clk);
		hw_trigger <= 1'b0;
		run(40);
		chk(12'(seen), 12'h0, "edge ignored");
		res(12'h456);
		wr(`ADCS_OFF_SC2, 8'h00);
		$display("test trigger done");
		vin <= 12'h2aa;
		wr(`ADCS_OFF_SC1, 8'h61);
		edge_wait();
		edge_wait();
		chk(12'(t <= 28), 12'h1, "first cont");
		edge_wait();
		chk(12'(t <= 20), 12'h1, "next cont");
		rd(`ADCS_OFF_RH, h);
		vin <= 12'h3cc;
		edge_wait();
		edge_wait();
		rd(`ADCS_OFF_RL, d);
		chk({h[3:0], d}, 12'h2aa, "blocked");
		$display("test continuous done");
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk(12'(active), 12'h0, "reset abort");
		res(12'h000);
		wr(`ADCS_OFF_CFG, 8'h94);
		@(negedge clk);
		chk(12'(low_power), 12'h1, "low power");
		vin <= 12'h055;
		wr(`ADCS_OFF_SC1, 8'h41);
		@(posedge clk);
		stop2_mode <= 1'b1;
		repeat (2) @(posedge clk);
		stop2_mode <= 1'b0;
		rdchk(`ADCS_OFF_CFG, 8'h00, "stop2 cfg");
		rdchk(`ADCS_OFF_SC1, 8'h1f, "stop2 sc1");
		res(12'h000);
		$display("test stop2 done");
		final_report();
	end
endmodule // adcs_sequencer_tb_top
